// file: core/sfc_pkg.sv
// Package of opcodes, field sizes and reset values for the serial flash command front end.
package sfc_pkg;

	// ==========================================================
	// Opcodes.
	localparam logic [7:0] OPC_SET_WRITE_PERMIT   = 8'h06;
	localparam logic [7:0] OPC_CLEAR_WRITE_PERMIT = 8'h04;
	localparam logic [7:0] OPC_FACTORY_SPEEDUP    = 8'h41;
	localparam logic [7:0] OPC_READ_THREE_BYTE_ID = 8'h9F;
	localparam logic [7:0] OPC_SIGNATURE_OR_WAKE  = 8'hAB;
	localparam logic [7:0] OPC_READ_MAKER_PART    = 8'h90;

	// ==========================================================
	// Frame layout.
	localparam logic [2:0] LAST_BIT_OF_BYTE       = 3'h7;
	localparam logic [1:0] SIGNATURE_DUMMY_LAST   = 2'h2;
	localparam logic [1:0] MAKER_PART_DUMMY_LAST  = 2'h1;
	localparam logic [7:0] ADDR_MAKER_FIRST       = 8'h00;
	localparam logic [7:0] ADDR_PART_FIRST        = 8'h01;
	localparam logic [4:0] LEN_THREE_BYTE_ID      = 5'h18;
	localparam logic [4:0] LEN_MAKER_PART        = 5'h10;
	localparam logic [4:0] LEN_SIGNATURE          = 5'h08;
	localparam logic [4:0] MSB_OF_OUT_WORD        = 5'h17;

	// ==========================================================
	// Reset values.
	localparam logic       RST_WRITE_PERMIT       = 1'b0;
	localparam logic       RST_FACTORY_MODE       = 1'b0;
	localparam logic       RST_OUT_ENABLE_N       = 1'b1;

	// ==========================================================
	// Frame states.
	typedef enum logic [2:0] {
		ST_IDLE     = 3'b000,
		ST_OPCODE   = 3'b001,
		ST_WAIT_END = 3'b010,
		ST_DUMMY    = 3'b011,
		ST_ADDR     = 3'b100,
		ST_OUT      = 3'b101,
		ST_STANDBY  = 3'b110
	} sfc_state_type;

endpackage

// file: core/sfc_edge.sv
// Edge finder for the serial clock and chip select pins.
`timescale 1ns/1ps
module sfc_edge
	import sfc_pkg::*;
(
	// Clock and reset.
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// Pins.
	input  wire logic sclk_i,
	input  wire logic cs_n_i,
	// Events.
	output logic      sclk_rise_o,
	output logic      sclk_fall_o,
	output logic      cs_fall_o,
	output logic      cs_rise_o
);

	// ==========================================================
	// State.
	typedef struct packed {
		logic sclk;
		logic cs_n;
	} sfc_edge_type;

	sfc_edge_type r_q;
	sfc_edge_type r_d;

	always_comb begin
		r_d      = r_q;
		r_d.sclk = sclk_i;
		r_d.cs_n = cs_n_i;
	end

	// Chip select idles high, so reset holds it high to avoid a false frame end.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			r_q.sclk <= 1'b0;
			r_q.cs_n <= 1'b1;
		end else begin
			r_q <= r_d;
		end
	end

	assign sclk_rise_o = sclk_i & ~r_q.sclk;
	assign sclk_fall_o = ~sclk_i & r_q.sclk;
	assign cs_fall_o   = ~cs_n_i & r_q.cs_n;
	assign cs_rise_o   = cs_n_i & ~r_q.cs_n;

endmodule

// file: core/sfc_core.sv
// Serial flash command front end: write permit, factory mode and identity readouts.
`timescale 1ns/1ps
module sfc_core
	import sfc_pkg::*;
#(
	// Identity values; all defaults are arbitrary.
	parameter logic [7:0] MAKER_CODE     = 8'h5A,
	parameter logic [7:0] MEM_TYPE_CODE  = 8'h3C,
	parameter logic [7:0] DENSITY_CODE   = 8'h11,
	parameter logic [7:0] SIGNATURE_CODE = 8'h66,
	parameter logic [7:0] PART_CODE      = 8'h77
) (
	// Clock and reset.
	input  wire logic       CORE_CLK_I,
	input  wire logic       RESETN_I,
	// Serial pins.
	input  wire logic       CS_N_I,
	input  wire logic       SCLK_I,
	input  wire logic       SI_I,
	input  wire logic [2:0] UPPER_MULTI_IO_LINES_I,
	output logic            SO_O,
	output logic            SO_OE_N_O,
	// Array engine status.
	input  wire logic       PROG_ERASE_BUSY_I,
	input  wire logic       STATUS_WRITE_DONE_I,
	input  wire logic       PAGE_PROGRAM_DONE_I,
	input  wire logic       SECTOR_ERASE_DONE_I,
	input  wire logic       HALF_BLOCK_ERASE_DONE_I,
	input  wire logic       BLOCK_ERASE_DONE_I,
	input  wire logic       CHIP_ERASE_DONE_I,
	// Flags and events.
	output logic            WRITE_PERMIT_LATCH_O,
	output logic            FACTORY_MODE_O,
	output logic            WAKE_PULSE_O
);

	// ==========================================================
	// State.
	typedef struct packed {
		sfc_state_type state;
		logic [7:0]    cmd;
		logic [7:0]    shin;
		logic [2:0]    bit_cnt;
		logic [1:0]    byte_cnt;
		logic [23:0]   data;
		logic [4:0]    len;
		logic [4:0]    idx;
		logic          so;
		logic          oe_n;
		logic          write_permit_latch;
		logic          fm;
		logic          wake;
	} sfc_core_type;

	sfc_core_type r_q;
	sfc_core_type r_d;

	logic sclk_rise;
	logic sclk_fall;
	logic cs_fall;
	logic cs_rise;

	// ==========================================================
	// Pin edges.
	// One register stage is enough, since the pins are taken as synchronous to the core clock.
	sfc_edge u_edge (
		.clk_i       (CORE_CLK_I),
		.rst_n_i     (RESETN_I),
		.sclk_i      (SCLK_I),
		.cs_n_i      (CS_N_I),
		.sclk_rise_o (sclk_rise),
		.sclk_fall_o (sclk_fall),
		.cs_fall_o   (cs_fall),
		.cs_rise_o   (cs_rise)
	);

	// Next index of a wrapping readout of the given length.
	function automatic logic [4:0] next_idx(input logic [4:0] idx, input logic [4:0] len);
		next_idx = (idx == len - 5'h01) ? 5'h00 : idx + 5'h01;
	endfunction

	// True for the opcodes that must stand alone between chip select edges.
	function automatic logic is_frame_only(input logic [7:0] opc);
		is_frame_only = (opc == OPC_SET_WRITE_PERMIT) ||
			(opc == OPC_CLEAR_WRITE_PERMIT) ||
			(opc == OPC_FACTORY_SPEEDUP);
	endfunction

	// True for the opcodes whose readout follows dummy bytes.
	function automatic logic has_dummy_bytes(input logic [7:0] opc);
		has_dummy_bytes = (opc == OPC_SIGNATURE_OR_WAKE) ||
			(opc == OPC_READ_MAKER_PART);
	endfunction

	// Maker and part codes in the order chosen by the address byte.
	// Any odd address acts as 01h, so every address gives a defined order.
	function automatic logic [23:0] maker_part_word(input logic [7:0] addr);
		if (addr == ADDR_MAKER_FIRST) begin
			maker_part_word = {MAKER_CODE, PART_CODE, 8'h00};
		end else if (addr == ADDR_PART_FIRST || addr[0]) begin
			maker_part_word = {PART_CODE, MAKER_CODE, 8'h00};
		end else begin
			maker_part_word = {MAKER_CODE, PART_CODE, 8'h00};
		end
	endfunction

	// Next value of a flag; a set in the same cycle beats any clear.
	function automatic logic flag_next(input logic q, input logic do_set, input logic do_clr);
		if (do_set) begin
			flag_next = 1'b1;
		end else if (do_clr) begin
			flag_next = 1'b0;
		end else begin
			flag_next = q;
		end
	endfunction

	// ==========================================================
	// Next state.
	logic [7:0] byte_in;
	logic       byte_done;
	logic       wel_set;
	logic       wel_clr;
	logic       fm_set;
	logic       fm_clr;

	always_comb begin
		r_d       = r_q;
		r_d.wake  = 1'b0;
		wel_set   = 1'b0;
		wel_clr   = 1'b0;
		fm_set    = 1'b0;
		byte_in   = {r_q.shin[6:0], SI_I};
		byte_done = (r_q.bit_cnt == LAST_BIT_OF_BYTE);
		// The upper multi-purpose lines are never read.
		if (cs_rise) begin
			// Frame end: only a whole opcode with nothing after it executes.
			if (r_q.state == ST_WAIT_END && is_frame_only(r_q.cmd)) begin
				if (r_q.cmd == OPC_SET_WRITE_PERMIT) begin
					wel_set = 1'b1;
				end else if (r_q.cmd == OPC_CLEAR_WRITE_PERMIT) begin
					wel_clr = 1'b1;
				end else if (r_q.cmd == OPC_FACTORY_SPEEDUP) begin
					fm_set = 1'b1;
				end
			end
			// Signature opcode alone is the wake command.
			if (r_q.state == ST_DUMMY && r_q.cmd == OPC_SIGNATURE_OR_WAKE &&
				r_q.byte_cnt == 2'h0 && r_q.bit_cnt == 3'h0) begin
				r_d.wake = 1'b1;
			end
			r_d.state = ST_IDLE;
			r_d.oe_n  = 1'b1;
		end else if (cs_fall) begin
			// A new frame restarts the counters, so a cut frame leaves nothing behind.
			r_d.state    = ST_OPCODE;
			r_d.bit_cnt  = 3'h0;
			r_d.byte_cnt = 2'h0;
			r_d.oe_n     = 1'b1;
		end else if (!CS_N_I && sclk_rise) begin
			// Inputs are taken on the rising clock edge.
			r_d.shin    = byte_in;
			r_d.bit_cnt = r_q.bit_cnt + 3'h1;
			case (r_q.state)
				ST_OPCODE: begin
					if (byte_done) begin
						// The readout index restarts so every readout opens with its first bit.
						r_d.cmd = byte_in;
						r_d.idx = 5'h00;
						if (is_frame_only(byte_in)) begin
							r_d.state = ST_WAIT_END;
						end else if (byte_in == OPC_READ_THREE_BYTE_ID) begin
							// A busy array engine leaves this opcode undecoded.
							if (PROG_ERASE_BUSY_I) begin
								r_d.state = ST_STANDBY;
							end else begin
								r_d.state = ST_OUT;
								r_d.data  = {MAKER_CODE, MEM_TYPE_CODE, DENSITY_CODE};
								r_d.len   = LEN_THREE_BYTE_ID;
							end
						end else if (has_dummy_bytes(byte_in)) begin
							r_d.state = ST_DUMMY;
						end else begin
							r_d.state = ST_STANDBY;
						end
					end
				end
				ST_WAIT_END: begin
					// Any bit after the opcode breaks the byte boundary.
					r_d.state = ST_STANDBY;
				end
				ST_DUMMY: begin
					if (byte_done) begin
						r_d.byte_cnt = r_q.byte_cnt + 2'h1;
						if (r_q.cmd == OPC_SIGNATURE_OR_WAKE &&
							r_q.byte_cnt == SIGNATURE_DUMMY_LAST) begin
							r_d.state = ST_OUT;
							r_d.data  = {SIGNATURE_CODE, 16'h0000};
							r_d.len   = LEN_SIGNATURE;
						end else if (r_q.cmd == OPC_READ_MAKER_PART &&
							r_q.byte_cnt == MAKER_PART_DUMMY_LAST) begin
							r_d.state = ST_ADDR;
						end
					end
				end
				ST_ADDR: begin
					if (byte_done) begin
						r_d.state = ST_OUT;
						r_d.len   = LEN_MAKER_PART;
						r_d.data  = maker_part_word(byte_in);
					end
				end
				ST_IDLE: begin
					// Clock activity without a frame start is ignored.
					r_d.state = ST_IDLE;
				end
				ST_OUT: begin
					// Input bits during a readout are don't-care.
					r_d.state = ST_OUT;
				end
				ST_STANDBY: begin
					r_d.state = ST_STANDBY;
				end
				default: begin
					// An unused state encoding falls back to idle.
					r_d.state = ST_IDLE;
				end
			endcase
		end else if (!CS_N_I && sclk_fall && r_q.state == ST_OUT) begin
			// Output changes on the falling edge, MSB first, wrapping.
			r_d.so   = r_q.data[MSB_OF_OUT_WORD - r_q.idx];
			r_d.oe_n = 1'b0;
			r_d.idx  = next_idx(r_q.idx, r_q.len);
		end
		// Completions clear the flags (a status write clears only the write permit), but a set in the same cycle wins.
		wel_clr = wel_clr | STATUS_WRITE_DONE_I | PAGE_PROGRAM_DONE_I |
			SECTOR_ERASE_DONE_I | HALF_BLOCK_ERASE_DONE_I |
			BLOCK_ERASE_DONE_I | CHIP_ERASE_DONE_I;
		fm_clr = PAGE_PROGRAM_DONE_I | SECTOR_ERASE_DONE_I |
			HALF_BLOCK_ERASE_DONE_I | BLOCK_ERASE_DONE_I |
			CHIP_ERASE_DONE_I;
		r_d.write_permit_latch = flag_next(r_q.write_permit_latch, wel_set, wel_clr);
		r_d.fm  = flag_next(r_q.fm, fm_set, fm_clr);
	end

	// ==========================================================
	// Registers.
	always_ff @(posedge CORE_CLK_I) begin
		if (!RESETN_I) begin
			r_q.state    <= ST_IDLE;
			r_q.cmd      <= '0;
			r_q.shin     <= '0;
			r_q.bit_cnt  <= '0;
			r_q.byte_cnt <= '0;
			r_q.data     <= '0;
			r_q.len      <= '0;
			r_q.idx      <= '0;
			r_q.so       <= 1'b0;
			r_q.oe_n     <= RST_OUT_ENABLE_N;
			r_q.write_permit_latch      <= RST_WRITE_PERMIT;
			r_q.fm       <= RST_FACTORY_MODE;
			r_q.wake     <= 1'b0;
		end else begin
			r_q <= r_d;
		end
	end

	// ==========================================================
	// Outputs.
	// Every output comes straight from a register, so nothing glitches at the pins.
	assign SO_O                 = r_q.so;
	assign SO_OE_N_O            = r_q.oe_n;
	assign WRITE_PERMIT_LATCH_O = r_q.write_permit_latch;
	assign FACTORY_MODE_O       = r_q.fm;
	assign WAKE_PULSE_O         = r_q.wake;

endmodule

// file: verif/sfc_core_asserts.sv
// Concurrent checks on the ports of the serial flash command front end.
`timescale 1ns/1ps
module sfc_core_asserts (
	// Clock, reset and pins.
	input wire logic CORE_CLK_I,
	input wire logic RESETN_I,
	input wire logic CS_N_I,
	input wire logic SCLK_I,
	// Completion events.
	input wire logic STATUS_WRITE_DONE_I,
	input wire logic PAGE_PROGRAM_DONE_I,
	// Outputs.
	input wire logic SO_O,
	input wire logic SO_OE_N_O,
	input wire logic WRITE_PERMIT_LATCH_O,
	input wire logic FACTORY_MODE_O,
	input wire logic WAKE_PULSE_O
);
	// ==========================================================
	// Assertions.
	default clocking cb @(posedge CORE_CLK_I);
	endclocking
	default disable iff (!RESETN_I);

	a_reset_quiet: assert property ($rose(RESETN_I) |-> SO_OE_N_O && !WRITE_PERMIT_LATCH_O &&
		!FACTORY_MODE_O && !WAKE_PULSE_O) else $error("Outputs not quiet after reset.");
	a_wake_one_cycle: assert property (WAKE_PULSE_O |=> !WAKE_PULSE_O)
		else $error("Wake pulse longer than one cycle.");
	a_release_after_cs: assert property (CS_N_I [*3] |-> SO_OE_N_O)
		else $error("Serial output still driven after chip select rise.");
	a_flag_set_frame: assert property ($rose(WRITE_PERMIT_LATCH_O) || $rose(FACTORY_MODE_O)
		|-> CS_N_I && $past(CS_N_I)) else $error("Flag set inside a frame.");
	a_pp_clears_flags: assert property (PAGE_PROGRAM_DONE_I && CS_N_I && $past(CS_N_I)
		|-> ##[1:2] (!FACTORY_MODE_O && !WRITE_PERMIT_LATCH_O)) else $error("Program end kept flags.");
	a_sw_clears_permit: assert property (STATUS_WRITE_DONE_I && CS_N_I && $past(CS_N_I)
		|-> ##[1:2] !WRITE_PERMIT_LATCH_O) else $error("Status write end kept permit.");
	a_drive_after_fall: assert property ($fell(SO_OE_N_O) |-> !$past(SCLK_I) && !$past(CS_N_I))
		else $error("Output enabled without clock fall.");
	a_so_change_fall: assert property ($changed(SO_O) && !SO_OE_N_O |-> !$past(SCLK_I))
		else $error("Serial output moved while clock high.");

	c_permit: cover property ($rose(WRITE_PERMIT_LATCH_O));
	c_wake: cover property (WAKE_PULSE_O);
	c_drive: cover property ($fell(SO_OE_N_O));
endmodule

bind sfc_core sfc_core_asserts sfc_core_asserts_inst (.CORE_CLK_I, .RESETN_I, .CS_N_I, .SCLK_I,
	.STATUS_WRITE_DONE_I, .PAGE_PROGRAM_DONE_I, .SO_O, .SO_OE_N_O, .WRITE_PERMIT_LATCH_O,
	.FACTORY_MODE_O, .WAKE_PULSE_O);

// file: verif/sfc_host_model.sv
// Behavioural SPI host that frames commands towards the flash command front end.
`timescale 1ns/1ps
module sfc_host_model (
	// Clock and device output.
	input  wire logic clk_i,
	input  wire logic so_i,
	input  wire logic so_oe_n_i,
	// Host pins.
	output logic      cs_n_o,
	output logic      sclk_o,
	output logic      si_o
);
	logic drove;
	logic mode3;
	logic so_line;

	// Nothing pulls the line, so a released output shows the inverse of its last bit.
	assign so_line = so_oe_n_i ? ~so_i : so_i;

	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		si_o   = 1'b0;
		drove  = 1'b0;
		mode3  = 1'b0;
	end

	// ==========================================================
	// Frame task.
	// Three low cycles per bit, so the output has settled before the rising edge takes it.
	task automatic xfer(input logic [31:0] tx, input int ntx, input int nrx,
		output logic [31:0] rx);
		rx    = 32'h0;
		drove = 1'b0;
		// The clock settles at its idle level, low in mode 0 and high in mode 3, before the frame.
		@(posedge clk_i);
		sclk_o <= mode3;
		@(posedge clk_i);
		cs_n_o <= 1'b0;
		for (int i = 0; i < ntx + nrx; i++) begin
			@(posedge clk_i);
			sclk_o <= 1'b0;
			si_o   <= (i < ntx) ? tx[31 - i] : ~si_o;
			repeat (3) @(posedge clk_i);
			sclk_o <= 1'b1;
			if (i >= ntx) begin
				rx    = {rx[30:0], so_line};
				drove = drove | ~so_oe_n_i;
			end
			@(posedge clk_i);
		end
		@(posedge clk_i);
		sclk_o <= mode3;
		repeat (3) @(posedge clk_i);
		cs_n_o <= 1'b1;
		si_o   <= ~si_o;
		repeat (4) @(posedge clk_i);
	endtask
endmodule

// file: verif/sfc_core_test.sv
// Self-checking bench for the serial flash command front end.
`timescale 1ns/1ps
module sfc_core_test;
	import sfc_pkg::*;
	// Identity values of the bench; all are arbitrary.
	localparam logic [7:0] MK = 8'hA5;
	localparam logic [7:0] TY = 8'h4B;
	localparam logic [7:0] DN = 8'h19;
	localparam logic [7:0] SG = 8'h3E;
	localparam logic [7:0] PT = 8'h72;
	logic        clk, rst_n, busy, cs_n, sclk, si, so, so_oe_n, write_permit_latch, fm, wake;
	logic [2:0]  upper;
	logic [5:0]  done;
	logic [31:0] rx, seed, e;
	int          fail_count, checked, cycles, wakes, ew, ef;
	logic [7:0]  idq[$];

	sfc_core #(.MAKER_CODE(MK), .MEM_TYPE_CODE(TY), .DENSITY_CODE(DN), .SIGNATURE_CODE(SG),
		.PART_CODE(PT)) sfc_core_inst (.CORE_CLK_I(clk), .RESETN_I(rst_n), .CS_N_I(cs_n),
		.SCLK_I(sclk), .SI_I(si), .UPPER_MULTI_IO_LINES_I(upper), .SO_O(so), .SO_OE_N_O(so_oe_n),
		.PROG_ERASE_BUSY_I(busy), .STATUS_WRITE_DONE_I(done[0]), .PAGE_PROGRAM_DONE_I(done[1]),
		.SECTOR_ERASE_DONE_I(done[2]), .HALF_BLOCK_ERASE_DONE_I(done[3]),
		.BLOCK_ERASE_DONE_I(done[4]), .CHIP_ERASE_DONE_I(done[5]),
		.WRITE_PERMIT_LATCH_O(write_permit_latch), .FACTORY_MODE_O(fm), .WAKE_PULSE_O(wake));
	sfc_host_model sfc_host_model_inst (.clk_i(clk), .so_i(so), .so_oe_n_i(so_oe_n),
		.cs_n_o(cs_n), .sclk_o(sclk), .si_o(si));

	// ==========================================================
	// Helpers.
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Bits of a repeating readout, first bit first, built from the queued bytes.
	function automatic logic [31:0] exp_bits(input int nbits);
		logic [31:0] v;
		logic [7:0]  byt;
		v = 32'h0;
		for (int b = 0; b < nbits; b++) begin
			byt = idq[(b / 8) % idq.size()];
			v = {v[30:0], byt[7 - (b % 8)]};
		end
		return v;
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		if (fail_count == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Short frame, then the flags against the model.
	task automatic cmd(input logic [7:0] opc, input int n, input int w, input int f);
		sfc_host_model_inst.xfer({opc, 24'h0}, n, 0, rx);
		ew = w;
		ef = f;
		@(negedge clk);
		check(32'({write_permit_latch, fm}), 32'({ew[0], ef[0]}));
	endtask

	// Read frame; a refused read must leave the output released.
	task automatic rd(input logic [31:0] tx, input int ntx, input int nrx, input logic drv);
		sfc_host_model_inst.xfer(tx, ntx, nrx, rx);
		check(32'(sfc_host_model_inst.drove), 32'(drv));
		if (drv) check(rx, e);
	endtask

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// The upper lines carry noise throughout, since the device must not care.
	always @(posedge clk) begin
		upper  <= 3'(rnd());
		cycles <= cycles + 1;
		if (wake === 1'b1) wakes <= wakes + 1;
		if (cycles == 20000) begin
			fail_count++;
			report_and_stop();
		end
	end

	// ==========================================================
	// Scenarios.
	initial begin
		seed = 32'hFCEC277E;
		rst_n = 1'b0;
		busy = 1'b0;
		done = 6'h00;
		upper = 3'h0;
		fail_count = 0;
		checked = 0;
		cycles = 0;
		wakes = 0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		check(32'({so_oe_n, write_permit_latch, fm, wake}), 32'h8);
		cmd(OPC_SET_WRITE_PERMIT, 8, 1, 0);
		cmd(OPC_CLEAR_WRITE_PERMIT, 8, 0, 0);
		cmd(OPC_SET_WRITE_PERMIT, 9, 0, 0);
		cmd(OPC_SET_WRITE_PERMIT, 8, 1, 0);
		cmd(OPC_CLEAR_WRITE_PERMIT, 7, 1, 0);
		for (int k = 0; k < 6; k++) begin
			cmd(OPC_SET_WRITE_PERMIT, 8, 1, ef);
			cmd(OPC_FACTORY_SPEEDUP, 8, 1, 1);
			@(posedge clk);
			done <= 6'h01 << k;
			@(posedge clk);
			done <= 6'h00;
			ew = 0;
			ef = (k == 0) ? ef : 0;
			repeat (2) @(negedge clk);
			check(32'({write_permit_latch, fm}), 32'({ew[0], ef[0]}));
		end
		cmd(OPC_SET_WRITE_PERMIT, 8, 1, 0);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		check(32'({write_permit_latch, fm}), 32'h0);
		idq = '{MK, TY, DN};
		e = exp_bits(32);
		rd({OPC_READ_THREE_BYTE_ID, 24'h0}, 8, 32, 1'b1);
		e = exp_bits(12);
		rd({OPC_READ_THREE_BYTE_ID, 24'h0}, 8, 12, 1'b1);
		cmd(OPC_SET_WRITE_PERMIT, 8, 1, 0);
		@(posedge clk);
		busy <= 1'b1;
		rd({OPC_READ_THREE_BYTE_ID, 24'h0}, 8, 16, 1'b0);
		busy <= 1'b0;
		idq = '{SG};
		e = exp_bits(16);
		rd({OPC_SIGNATURE_OR_WAKE, 24'(rnd())}, 32, 16, 1'b1);
		check(32'(wakes), 32'h0);
		cmd(OPC_SIGNATURE_OR_WAKE, 8, 1, 0);
		check(32'(wakes), 32'h1);
		for (int a = 0; a < 2; a++) begin
			idq = '{(a == 0) ? MK : PT, (a == 0) ? PT : MK};
			e = exp_bits(32);
			rd({OPC_READ_MAKER_PART, 16'(rnd()), 8'(a)}, 32, 32, 1'b1);
		end
		sfc_host_model_inst.mode3 = 1'b1;
		idq = '{MK, TY, DN};
		e = exp_bits(32);
		rd({OPC_READ_THREE_BYTE_ID, 24'h0}, 8, 32, 1'b1);
		cmd(OPC_CLEAR_WRITE_PERMIT, 8, 0, 0);
		sfc_host_model_inst.mode3 = 1'b0;
		rd({8'h03, 24'h0}, 8, 16, 1'b0);
		cmd(OPC_SET_WRITE_PERMIT, 8, 1, 0);
		report_and_stop();
	end
endmodule
